/* File: bsf_pkg.sv */
package bsf_pkg;
    // Status bit positions and vector widths
    localparam int unsigned ST_BUCK_OC = 0;
    localparam int unsigned ST_BUCK_LOW = 1;
    localparam int unsigned ST_BROWNOUT = 2;
    localparam int unsigned ST_VDD_UV = 3;
    localparam int unsigned ST_VDD_OV = 4;
    localparam int unsigned ST_TEMP_WARN = 5;
    localparam int unsigned ST_TEMP_SD = 6;
    localparam int unsigned ST_W = 7;
    localparam int unsigned CMP_W = 11;

    // Register offsets, reset values and control bit positions
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_IRQ = 4'h1;
    localparam logic [3:0] REG_MASK = 4'h2;
    localparam logic [3:0] REG_CTRL = 4'h3;
    localparam logic [ST_W-1:0] MASK_RST = 7'h00;
    localparam logic [1:0] CTRL_RST = 2'h3;
    localparam int unsigned CTRL_MSG_EN = 0;
    localparam int unsigned CTRL_WARN_EN = 1;

    // Serial link timing
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned BAUD = 9600;
    localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
    localparam int unsigned BIT_CNT_W = 14;
    localparam int unsigned FRAME_BITS = 10;

    // Message codes sent on the host link
    localparam logic [7:0] MSG_STATUS = 8'h5a;
    localparam logic [7:0] MSG_WARN = 8'ha5;
    localparam logic [7:0] MSG_BROWNOUT = 8'hb0;

    typedef struct packed {
        logic buck_oc;      // Switch current above limit
        logic buck_lt90;    // Output below 90 %
        logic buck_ge94;    // Output at or above 94 %
        logic buck_lt80;    // Output below 80 %
        logic vdd_ov_stop;  // Above overvoltage stop level
        logic vdd_uv_stop;  // Below undervoltage stop level
        logic vdd_uv_drv;   // Below driver undervoltage level
        logic vdd_ov_ext;   // Extreme overvoltage
        logic pump_start;   // Below pump start level
        logic temp_warn;    // Temperature warning
        logic temp_hot;     // Above shutdown threshold
    } bsf_cmp_s;

    typedef struct packed {
        logic buck_en;
        logic pump_en;
        logic drv_en;
        logic amp_en;
        logic ldo12_en;
        logic ldo5_en;
        logic link_en;
    } bsf_en_s;
endpackage

/* File: bsf_uart_tx.sv */
`timescale 1ns/1ns
`default_nettype none
// Open-drain 8N1 transmitter, LSB first
module bsf_uart_tx (
    input wire logic clk_i,          // Clock
    input wire logic rst_n_i,        // Sync reset
    input wire logic valid_i,        // Byte offered
    input wire logic [7:0] data_i,   // Byte
    output logic ready_o,            // Idle, takes byte
    output logic od_oe_o             // Pull line low
);
    import bsf_pkg::*;

    typedef struct packed {
        logic busy;
        logic [9:0] shift;
        logic [3:0] bit_n;
        logic [BIT_CNT_W-1:0] cnt;
        logic oe;
    } bsf_tx_s;

    bsf_tx_s s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (!s_q.busy) begin
            s_d.oe = 1'b0;
            if (valid_i) begin
                s_d.busy = 1'b1;
                s_d.shift = {1'b1, data_i, 1'b0};
                s_d.bit_n = 4'h0;
                s_d.cnt = '0;
                s_d.oe = 1'b1;
            end
        end else if (s_q.cnt == BIT_CNT_W'(BIT_CYC - 1)) begin
            s_d.cnt = '0;
            if (s_q.bit_n == 4'(FRAME_BITS - 1)) begin
                s_d.busy = 1'b0;
                s_d.oe = 1'b0;
            end else begin
                s_d.bit_n = s_q.bit_n + 4'h1;
                s_d.shift = {1'b1, s_q.shift[9:1]};
                s_d.oe = ~s_q.shift[1];
            end
        end else begin
            s_d.cnt = s_q.cnt + BIT_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ready_o = !s_q.busy;
    assign od_oe_o = s_q.oe;
endmodule
`default_nettype wire

/* File: bsf_supervisor.sv */
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Overcurrent bit follows limit, queues message
// - Low-output bit sets 90%, clears 94%
// - Below 80% latches brown-out, notifies host
// - Overvoltage stop disables buck
// - Undervoltage stop disables buck
// - Feedback held at supply shuts buck
// - Pump on only below start level
// - Undervoltage kills drivers, rest runs
// - Undervoltage sends status message
// - Extreme overvoltage turns everything off
// - Overheat turns all off, latches fault
// - Overheat recovery needs cool and CE toggle
// - Warn host before overheat shutdown
// - Latched faults clear on CE rise
// - CE low disables bridge, amps, 12V
// - Link is 9600 baud 8N1 open drain
// - Current fault pin low during motor fault
module bsf_supervisor (
    input wire logic clk_i,                 // Clock
    input wire logic rst_n_i,               // Sync reset, active low
    input wire bsf_pkg::bsf_cmp_s cmp_i,    // Async comparator results
    input wire logic fb_at_supply_i,        // Feedback pin held high
    input wire logic chip_en_i,             // Chip enable pin
    input wire logic ilimit_trip_i,         // Current limit comparator
    input wire logic motor_fault_i,         // Driver logic fault
    input wire logic [3:0] addr_i,          // Register address
    input wire logic [7:0] wdata_i,         // Write data
    input wire logic wr_i,                  // Write strobe
    input wire logic rd_i,                  // Read strobe
    output logic [7:0] rdata_o,             // Read data, next cycle
    output logic irq_o,                     // Level interrupt
    output bsf_pkg::bsf_en_s en_o,          // Function enables
    output logic host_link_pin_oe_o,        // Pull host link low
    output logic current_fault_out_oe_o     // Pull fault pin low
);
    import bsf_pkg::*;

    typedef struct packed {
        bsf_cmp_s cmp_m;
        bsf_cmp_s cmp;
        logic fb_m;
        logic fb;
        logic ce_m;
        logic ce;
        logic ce_prev;
        logic ilim_m;
        logic ilim;
        logic fault_m;
        logic fault;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] irq;
        logic [ST_W-1:0] mask;
        logic [1:0] ctrl;
        logic brownout;
        logic ot_latch;
        logic pend_status;
        logic pend_warn;
        logic pend_brown;
        logic [7:0] rdata;
    } bsf_state_s;

    bsf_state_s s_q, s_d;
    logic tx_ready;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_oe;
    logic [ST_W-1:0] live;
    logic [ST_W-1:0] events;
    logic ce_rise;

    // Live status view built from synchronised levels
    always_comb begin
        live = s_q.status;
        live[ST_BUCK_OC] = s_q.cmp.buck_oc;
        if (s_q.cmp.buck_lt90) begin
            live[ST_BUCK_LOW] = 1'b1;
        end else if (s_q.cmp.buck_ge94) begin
            live[ST_BUCK_LOW] = 1'b0;
        end
        live[ST_BROWNOUT] = s_q.brownout;
        live[ST_VDD_UV] = s_q.cmp.vdd_uv_drv;
        live[ST_VDD_OV] = s_q.cmp.vdd_ov_ext;
        live[ST_TEMP_WARN] = s_q.cmp.temp_warn;
        live[ST_TEMP_SD] = s_q.ot_latch;
    end

    assign events = live & ~s_q.status;
    assign ce_rise = s_q.ce & ~s_q.ce_prev;

    always_comb begin
        s_d = s_q;
        // Two-stage synchronisers
        s_d.cmp_m = cmp_i;
        s_d.cmp = s_q.cmp_m;
        s_d.fb_m = fb_at_supply_i;
        s_d.fb = s_q.fb_m;
        s_d.ce_m = chip_en_i;
        s_d.ce = s_q.ce_m;
        s_d.ce_prev = s_q.ce;
        s_d.ilim_m = ilimit_trip_i;
        s_d.ilim = s_q.ilim_m;
        s_d.fault_m = motor_fault_i;
        s_d.fault = s_q.fault_m;

        // Latched faults clear only on CE rise once condition gone
        if (ce_rise && !s_q.cmp.buck_lt80) begin
            s_d.brownout = 1'b0;
        end
        if (ce_rise && !s_q.cmp.temp_hot) begin
            s_d.ot_latch = 1'b0;
        end
        if (s_q.cmp.buck_lt80) begin
            s_d.brownout = 1'b1;
        end
        if (s_q.cmp.temp_hot) begin
            s_d.ot_latch = 1'b1;
        end

        s_d.status = live;

        // Message requests; set beats clear on the same cycle
        if (tx_valid && tx_ready) begin
            if (s_q.pend_brown) begin
                s_d.pend_brown = 1'b0;
            end else if (s_q.pend_status) begin
                s_d.pend_status = 1'b0;
            end else begin
                s_d.pend_warn = 1'b0;
            end
        end
        if (events[ST_BUCK_OC] || events[ST_BUCK_LOW]
            || events[ST_VDD_UV]) begin
            s_d.pend_status = 1'b1;
        end
        if (events[ST_BROWNOUT]) begin
            s_d.pend_brown = 1'b1;
        end
        if (events[ST_TEMP_WARN] && s_q.ctrl[CTRL_WARN_EN]) begin
            s_d.pend_warn = 1'b1;
        end

        // Sticky interrupt bits; read clears, new event wins
        s_d.rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                REG_STATUS: s_d.rdata = 8'(s_q.status);
                REG_IRQ: begin
                    s_d.rdata = 8'(s_q.irq);
                    s_d.irq = '0;
                end
                REG_MASK: s_d.rdata = 8'(s_q.mask);
                REG_CTRL: s_d.rdata = 8'(s_q.ctrl);
                default: s_d.rdata = 8'h00;
            endcase
        end
        s_d.irq = s_d.irq | events;
        if (wr_i) begin
            if (addr_i == REG_MASK) begin
                s_d.mask = wdata_i[ST_W-1:0];
            end
            if (addr_i == REG_CTRL) begin
                s_d.ctrl = wdata_i[1:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            s_q.mask <= MASK_RST;
            s_q.ctrl <= CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Brown-out first: host must learn configuration is lost
    always_comb begin
        tx_data = MSG_WARN;
        if (s_q.pend_brown) begin
            tx_data = MSG_BROWNOUT;
        end else if (s_q.pend_status) begin
            tx_data = MSG_STATUS;
        end
    end
    assign tx_valid = s_q.ctrl[CTRL_MSG_EN] && en_o.link_en
        && (s_q.pend_brown || s_q.pend_status || s_q.pend_warn);

    bsf_uart_tx u_tx (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .valid_i(tx_valid),
        .data_i(tx_data),
        .ready_o(tx_ready),
        .od_oe_o(tx_oe)
    );

    // Enables derive from synchronised levels and latches
    logic all_off;
    assign all_off = s_q.cmp.vdd_ov_ext || s_q.ot_latch;

    always_comb begin
        en_o.buck_en = !all_off && !s_q.brownout
            && !s_q.cmp.vdd_ov_stop
            && !s_q.cmp.vdd_uv_stop
            && !s_q.fb;
        en_o.pump_en = !all_off && s_q.cmp.pump_start;
        en_o.drv_en = !all_off && !s_q.brownout && s_q.ce
            && !s_q.cmp.vdd_uv_drv;
        en_o.amp_en = !all_off && !s_q.brownout && s_q.ce;
        en_o.ldo12_en = !all_off && !s_q.brownout && s_q.ce;
        en_o.ldo5_en = !all_off;
        en_o.link_en = !all_off;
    end

    // Link pin released when link shut off
    assign host_link_pin_oe_o = tx_oe && en_o.link_en;
    assign current_fault_out_oe_o = s_q.ilim || s_q.fault;
    assign irq_o = |(s_q.irq & s_q.mask);
    assign rdata_o = s_q.rdata;
endmodule
`default_nettype wire

/* File: bsf_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module bsf_checker
    import bsf_pkg::*;
(
    input wire logic clk_i,                  // Clock
    input wire logic rst_n_i,                // Sync reset
    input wire bsf_cmp_s cmp_i,              // Comparators
    input wire logic fb_at_supply_i,         // Feedback at supply
    input wire logic chip_en_i,              // Chip enable
    input wire logic ilimit_trip_i,          // Current limit
    input wire logic motor_fault_i,          // Driver fault
    input wire bsf_en_s en_o,                // Enables
    input wire logic host_link_pin_oe_o,     // Link pull
    input wire logic current_fault_out_oe_o  // Fault pin pull
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic flt = ilimit_trip_i | motor_fault_i;

    a_ov_stop_buck: assert property (
        cmp_i.vdd_ov_stop [*4] |-> !en_o.buck_en)
        else $error("buck on above overvoltage stop");
    a_uv_stop_buck: assert property (
        cmp_i.vdd_uv_stop [*4] |-> !en_o.buck_en)
        else $error("buck on below undervoltage stop");
    a_fb_buck_off: assert property (
        fb_at_supply_i [*4] |-> !en_o.buck_en)
        else $error("buck on with feedback at supply");
    a_pump_idle: assert property (
        !cmp_i.pump_start [*4] |-> !en_o.pump_en)
        else $error("pump on above start level");
    a_uv_drv_off: assert property (
        cmp_i.vdd_uv_drv [*4] |-> !en_o.drv_en)
        else $error("drivers on in undervoltage");
    a_ext_ov_off: assert property (
        cmp_i.vdd_ov_ext [*4] |-> en_o == '0 && !host_link_pin_oe_o)
        else $error("function alive in extreme overvoltage");
    a_hot_all_off: assert property (
        cmp_i.temp_hot [*4] |-> en_o == '0)
        else $error("function alive while overheated");
    a_ce_low_off: assert property (
        !chip_en_i [*4] |-> !(en_o.drv_en | en_o.amp_en | en_o.ldo12_en))
        else $error("bridge or 12V on with chip enable low");
    a_fault_pin_on: assert property (
        flt [*3] |-> current_fault_out_oe_o)
        else $error("fault pin released during fault");
    a_fault_pin_off: assert property (
        !flt [*3] |-> !current_fault_out_oe_o)
        else $error("fault pin pulled without fault");
    a_sync_delay: assert property (
        !flt [*2] ##1 flt |=> !current_fault_out_oe_o)
        else $error("fault input used before synchronising");

    c_hot: cover property (cmp_i.temp_hot ##4 en_o == '0);
    c_link: cover property ($rose(host_link_pin_oe_o));
    c_fault: cover property ($rose(current_fault_out_oe_o));
endmodule

bind bsf_supervisor bsf_checker u_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cmp_i(cmp_i),
    .fb_at_supply_i(fb_at_supply_i), .chip_en_i(chip_en_i),
    .ilimit_trip_i(ilimit_trip_i), .motor_fault_i(motor_fault_i),
    .en_o(en_o), .host_link_pin_oe_o(host_link_pin_oe_o),
    .current_fault_out_oe_o(current_fault_out_oe_o)
);
`default_nettype wire

/* File: bsf_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Host receiver: sees the open-drain line through its pull-up
module bsf_host_model
    import bsf_pkg::*;
(
    input wire logic clk_i,        // Clock
    input wire logic rst_n_i,      // Sync reset
    input wire logic link_oe_i,    // Device pulls line low
    output logic [7:0] starts_o,   // Falling edges seen on line
    output logic bit1_o,           // Second data bit of first byte
    output logic bit1_ok_o         // Second data bit sampled
);
    wire logic line = !link_oe_i;
    logic line_q;
    int cnt;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            line_q <= 1'b1;
            starts_o <= '0;
            cnt <= 0;
            bit1_o <= 1'b0;
            bit1_ok_o <= 1'b0;
        end else begin
            line_q <= line;
            if (line_q && !line) begin
                starts_o <= starts_o + 8'h01;
            end
            if (starts_o != 8'h00 && !bit1_ok_o) begin
                cnt <= cnt + 1;
            end
            // Middle of data bit 1, LSB first at 9600 baud
            if (cnt == BIT_CYC * 5 / 2) begin
                bit1_o <= line;
                bit1_ok_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: test_bias_supervisor_fault_logic.sv */
`timescale 1ns/1ns
`default_nettype none
module test_bias_supervisor_fault_logic;
    import bsf_pkg::*;
    typedef struct packed {
        bsf_cmp_s c;
        logic fb;
        logic ce;
        logic [6:0] e;
    } bsf_row_s;
    logic clk_i = 0, rst_n_i = 0, fb_i = 0, ce_i = 1, ilim_i = 0, mf_i = 0;
    bsf_cmp_s cmp_i = 11'h100;
    logic [3:0] addr_i = '0;
    logic [7:0] wdata_i = '0, rdata_o, starts, ex;
    logic wr_i = 0, rd_i = 0, irq_o, link_oe, flt_oe, bit1, bit1_ok;
    bsf_en_s en_o;
    int err_count = 0, compares = 0;
    // Ordinary supply cases: comparators, feedback, CE, expected enables
    bsf_row_s rows[7] = '{'{11'h100, 1'b0, 1'b1, 7'h5f},
        '{11'h140, 1'b0, 1'b1, 7'h1f}, '{11'h130, 1'b0, 1'b1, 7'h0f},
        '{11'h110, 1'b0, 1'b1, 7'h4f}, '{11'h104, 1'b0, 1'b1, 7'h7f},
        '{11'h100, 1'b1, 1'b1, 7'h1f}, '{11'h100, 1'b0, 1'b0, 7'h43}};

    bsf_supervisor DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmp_i(cmp_i),
        .fb_at_supply_i(fb_i), .chip_en_i(ce_i), .ilimit_trip_i(ilim_i),
        .motor_fault_i(mf_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
        .en_o(en_o), .host_link_pin_oe_o(link_oe),
        .current_fault_out_oe_o(flt_oe));
    bsf_host_model u_host (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .link_oe_i(link_oe), .starts_o(starts), .bit1_o(bit1),
        .bit1_ok_o(bit1_ok));

    always #4 clk_i = ~clk_i;

    task automatic chk(input string n, input logic [7:0] g, e);
        compares++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask
    // Synchronisers need three edges, latched bits four, before status reflects inputs
    task automatic settle();
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    task automatic setc(input bsf_cmp_s c);
        @(posedge clk_i);
        cmp_i <= c;
        settle();
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata", rdata_o, e);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic cetoggle();
        @(posedge clk_i);
        ce_i <= 1'b0;
        settle();
        @(posedge clk_i);
        ce_i <= 1'b1;
        settle();
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk("en_reset", {1'b0, en_o}, 8'h43);
        chk("irq_reset", {7'h00, irq_o}, 8'h00);
        rdc(REG_CTRL, 8'h03);
        rdc(REG_MASK, 8'h00);
        $display("reset done");
        foreach (rows[i]) begin
            @(posedge clk_i);
            cmp_i <= rows[i].c;
            fb_i <= rows[i].fb;
            ce_i <= rows[i].ce;
            settle();
            ex = {1'b0, rows[i].e};
            chk("en", {1'b0, en_o}, ex);
        end
        $display("supply rows done");
        chk("link_starts", starts, 8'h01);
        rdc(REG_IRQ, 8'h08);
        setc(11'h500);
        rdc(REG_STATUS, 8'h01);
        chk("irq_masked", {7'h00, irq_o}, 8'h00);
        wr(REG_MASK, 8'h01);
        #1;
        chk("irq_on", {7'h00, irq_o}, 8'h01);
        rdc(REG_IRQ, 8'h01);
        chk("irq_clear", {7'h00, irq_o}, 8'h00);
        setc(11'h100);
        rdc(REG_STATUS, 8'h00);
        setc(11'h200);
        rdc(REG_STATUS, 8'h02);
        setc(11'h000);
        rdc(REG_STATUS, 8'h02);
        setc(11'h100);
        rdc(REG_STATUS, 8'h00);
        setc(11'h102);
        rdc(REG_STATUS, 8'h20);
        wr(4'h5, 8'hff);
        rdc(4'h5, 8'h00);
        $display("status and interrupt done");
        @(posedge clk_i);
        mf_i <= 1'b1;
        settle();
        chk("fault_pin", {7'h00, flt_oe}, 8'h01);
        @(posedge clk_i);
        mf_i <= 1'b0;
        ilim_i <= 1'b1;
        settle();
        chk("fault_pin", {7'h00, flt_oe}, 8'h01);
        @(posedge clk_i);
        ilim_i <= 1'b0;
        settle();
        chk("fault_pin", {7'h00, flt_oe}, 8'h00);
        setc(11'h280);
        rdc(REG_STATUS, 8'h06);
        setc(11'h101);
        chk("en_hot", {1'b0, en_o}, 8'h00);
        rdc(REG_STATUS, 8'h44);
        // Toggle while still hot must not release the latch
        cetoggle();
        chk("en_still_hot", {1'b0, en_o}, 8'h00);
        setc(11'h100);
        chk("en_latched", {1'b0, en_o}, 8'h00);
        cetoggle();
        chk("en_recovered", {1'b0, en_o}, 8'h5f);
        rdc(REG_STATUS, 8'h00);
        $display("latched faults done");
        for (int n = 0; n < 40000 && !bit1_ok; n++) @(posedge clk_i);
        chk("link_wait", {7'h00, bit1_ok}, 8'h01);
        if (bit1_ok) begin
            chk("link_bit1", {7'h00, bit1}, 8'h01);
            setc(11'h108);
            chk("en_ext_ov", {1'b0, en_o}, 8'h00);
            chk("link_ext_ov", {7'h00, link_oe}, 8'h00);
        end
        $display("link and overvoltage done");
        complete_run();
    end
endmodule
`default_nettype wire
